// ==== udc_counter.sv ====
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`include "udc_regs.svh"

module udc_counter
    import udc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int ADR_WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [WIDTH-1:0] count_value_o,
    output logic upper_limit_flag_o,
    output logic zero_flag_o,
    output logic irq_o
);

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] udc_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Bus access state
    logic req;
    logic wr_take;
    logic rd_take;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_take = req && wb_we_i && wb_ack_o;
    assign rd_take = req && !wb_we_i && wb_ack_o;

    logic [ADR_WIDTH-1:0] ofs_ctrl;
    logic [ADR_WIDTH-1:0] ofs_preset;
    logic [ADR_WIDTH-1:0] ofs_count;
    logic [ADR_WIDTH-1:0] ofs_flags;
    logic [ADR_WIDTH-1:0] ofs_istat;
    logic [ADR_WIDTH-1:0] ofs_imask;
    assign ofs_ctrl = ADR_WIDTH'(`UDC_CTRL_OFS);
    assign ofs_preset = ADR_WIDTH'(`UDC_PRESET_OFS);
    assign ofs_count = ADR_WIDTH'(`UDC_COUNT_OFS);
    assign ofs_flags = ADR_WIDTH'(`UDC_FLAGS_OFS);
    assign ofs_istat = ADR_WIDTH'(`UDC_IRQ_STAT_OFS);
    assign ofs_imask = ADR_WIDTH'(`UDC_IRQ_MASK_OFS);

    // Registers
    udc_ctrl_t ctrl;
    udc_ctrl_t ctrl_prev;
    logic signed [WIDTH-1:0] preset;
    logic signed [WIDTH-1:0] count;
    logic signed [WIDTH-1:0] next_count;
    logic signed [WIDTH-1:0] next_preset;
    udc_flags_t flags;
    udc_flags_t next_flags;
    udc_flags_t irq_stat;
    udc_flags_t irq_mask;

    // Ack answers one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    // Read data, registered alongside the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= 32'h0;
            if (wb_adr_i == ofs_ctrl) begin
                wb_dat_o <= 32'(ctrl);
            end else if (wb_adr_i == ofs_preset) begin
                wb_dat_o <= 32'($unsigned(preset));
            end else if (wb_adr_i == ofs_count) begin
                wb_dat_o <= 32'($unsigned(count));
            end else if (wb_adr_i == ofs_flags) begin
                wb_dat_o <= 32'(flags);
            end else if (wb_adr_i == ofs_istat) begin
                wb_dat_o <= 32'(irq_stat);
            end else if (wb_adr_i == ofs_imask) begin
                wb_dat_o <= 32'(irq_mask);
            end
        end
    end

    // Control bits written by software stand for the block inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `UDC_CTRL_RST;
        end else if (wr_take && wb_adr_i == ofs_ctrl) begin
            ctrl <= udc_ctrl_t'(4'(udc_merge(32'(ctrl), wb_dat_i,
                                             wb_sel_i)));
        end
    end

    // Previous-cycle copy of the inputs for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_prev <= `UDC_CTRL_RST;
        end else begin
            ctrl_prev <= ctrl;
        end
    end

    // Preset write
    always_comb begin
        next_preset = preset;
        if (wr_take && wb_adr_i == ofs_preset) begin
            next_preset = WIDTH'(udc_merge(32'($unsigned(preset)), wb_dat_i,
                                           wb_sel_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset <= '0;
        end else begin
            preset <= next_preset;
        end
    end

    // Edge and limit decode
    logic up_edge;
    logic down_edge;
    logic permit;
    logic at_upper;
    logic at_zero;
    logic up_ok;
    logic down_ok;
    assign up_edge = ctrl.up && !ctrl_prev.up;
    assign down_edge = ctrl.down && !ctrl_prev.down;
    assign permit = !ctrl.clear && !ctrl.load;
    assign at_upper = (count == preset);
    assign at_zero = (count == '0);
    assign up_ok = up_edge && !at_upper;
    assign down_ok = down_edge && !at_zero;

    // Next count: clear over load over counting; opposing steps cancel
    always_comb begin
        next_count = count;
        if (ctrl.clear) begin
            next_count = '0;
        end else if (ctrl.load) begin
            next_count = preset;
        end else if (permit) begin
            if (up_ok && !down_ok) begin
                next_count = WIDTH'(count + WIDTH'(1));
            end else if (down_ok && !up_ok) begin
                next_count = WIDTH'(count - WIDTH'(1));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Flags follow the values the count and preset are taking
    always_comb begin
        next_flags.upper = (next_count == next_preset);
        next_flags.zero = (next_count == '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= udc_flags_t'(`UDC_FLAGS_INIT);
        end else begin
            flags <= next_flags;
        end
    end

    // Flag rising edges and a read of the status register
    udc_flags_t stat_rise;
    logic stat_read;
    assign stat_rise = udc_flags_t'(next_flags & ~flags);
    assign stat_read = rd_take && wb_adr_i == ofs_istat;

    // Sticky status on flag rising edges; a read clears only what it
    // reported, so an event landing during the read is kept; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= `UDC_FLAGS_RST;
        end else begin
            for (int i = 0; i < $bits(udc_flags_t); i++) begin
                if (stat_rise[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (stat_read && wb_dat_o[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `UDC_MASK_RST;
        end else if (wr_take && wb_adr_i == ofs_imask) begin
            irq_mask <= udc_flags_t'(2'(udc_merge(32'(irq_mask), wb_dat_i,
                                                  wb_sel_i)));
        end
    end

    // Outputs
    assign count_value_o = count;
    assign upper_limit_flag_o = flags.upper;
    assign zero_flag_o = flags.zero;
    assign irq_o = |(irq_stat & irq_mask);

    // Checks
    sequence clear_seq;
        ctrl.clear;
    endsequence

    sequence load_seq;
        !ctrl.clear && ctrl.load;
    endsequence

    sequence step_up_seq;
        permit && up_edge && !down_edge;
    endsequence

    sequence step_down_seq;
        permit && down_edge && !up_edge;
    endsequence

    // Load while the preset is not being rewritten
    sequence steady_load_seq;
        load_seq and !(wr_take && wb_adr_i == ofs_preset);
    endsequence

    // Bus request that has no answer out yet
    sequence bus_req_seq;
        req && !wb_ack_o;
    endsequence

    property p_count_hold;
        @(posedge clk_i) disable iff (rst_i)
            (permit && !up_edge && !down_edge) |=> $stable(count);
    endproperty

    // Without an input edge, and with clear and load low, the count stays put
    count_hold_a: assert property (p_count_hold)
        else $error("count moved without an edge");

    // A permitted up edge below the limit adds one
    count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_up_seq and !at_upper |=>
            count == WIDTH'($past(count) + WIDTH'(1)))
        else $error("count-up edge did not add one");

    // A permitted down edge above zero subtracts one
    count_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_down_seq and !at_zero |=>
            count == WIDTH'($past(count) - WIDTH'(1)))
        else $error("count-down edge did not subtract one");

    // Up edges are ignored at the limit
    upper_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_up_seq and at_upper |=> $stable(count))
        else $error("count passed the upper limit");

    // Down edges are ignored at zero
    zero_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_down_seq and at_zero |=> count == '0)
        else $error("count went below zero");

    // Clear forces zero and raises the zero flag
    clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_seq |=> count == '0 && zero_flag_o)
        else $error("clear did not force zero");

    // Load copies the old preset in
    load_preset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        load_seq |=> count == $past(preset))
        else $error("load did not copy preset");

    // A steady load leaves the count at the limit
    load_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        steady_load_seq |=> upper_limit_flag_o)
        else $error("load did not reach the limit");

    // Flags always agree with the count and the preset
    flag_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
        upper_limit_flag_o == (count == preset) &&
        zero_flag_o == (count == '0))
        else $error("flags disagree with count");

    // Opposing edges in one cycle cancel when neither limit blocks a step
    both_edges_a: assert property (@(posedge clk_i) disable iff (rst_i)
        permit && up_ok && down_ok |=> $stable(count))
        else $error("opposing edges moved the count");

    // Ack comes one cycle after the request
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req_seq |=> wb_ack_o)
        else $error("request not answered in one cycle");

    // Ack is a single-cycle pulse
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Mask write lands at the ack edge
    mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && wb_adr_i == ofs_imask && wb_sel_i[0] |=>
            irq_mask == udc_flags_t'($past(wb_dat_i[1:0])))
        else $error("mask write did not land");

    // Preset write lands at the ack edge
    preset_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && wb_adr_i == ofs_preset && wb_sel_i[1:0] == 2'b11 |=>
            preset == $past(wb_dat_i[WIDTH-1:0]))
        else $error("preset write did not land");

    // Upper flag rising leaves its status bit set
    irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(upper_limit_flag_o) |-> irq_stat.upper)
        else $error("upper event not latched");

    // Zero flag rising leaves its status bit set
    irq_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(zero_flag_o) |-> irq_stat.zero)
        else $error("zero event not latched");

    // A status read clears what it reported unless an event lands
    stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stat_read |=>
            (irq_stat & $past(wb_dat_o[1:0]) & ~$past(stat_rise)) == '0)
        else $error("status read did not clear");

    // An unmasked event raises the interrupt line
    irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |(stat_rise & irq_mask) && !(wr_take && wb_adr_i == ofs_imask)
            |=> irq_o)
        else $error("unmasked event did not raise the interrupt");

endmodule

// ==== udc_regs.svh ====
// Operation
// - Count changes only while clear and preset-load are both low; here clear also forces it to zero and load copies the preset in.
// - A rising edge on count-up adds one when counting is allowed.
// - A rising edge on count-down subtracts one when counting is allowed.
// - Count equal to preset raises upper flag and blocks count-up.
// - Count equal to zero raises zero flag and blocks count-down.
// - While clear is high, counting stops and count is forced to zero.
// - While preset-load is high, counting stops and preset is copied in.
// - One preset value is both the upper limit and the load value.
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH

// Register byte offsets
`define UDC_CTRL_OFS 8'h00
`define UDC_PRESET_OFS 8'h04
`define UDC_COUNT_OFS 8'h08
`define UDC_FLAGS_OFS 8'h0c
`define UDC_IRQ_STAT_OFS 8'h10
`define UDC_IRQ_MASK_OFS 8'h14

// Control register bit positions
`define UDC_CTRL_UP_BIT 0
`define UDC_CTRL_DOWN_BIT 1
`define UDC_CTRL_CLEAR_BIT 2
`define UDC_CTRL_LOAD_BIT 3

// Flag and interrupt bit positions
`define UDC_FLAG_UPPER_BIT 0
`define UDC_FLAG_ZERO_BIT 1

// Reset values
`define UDC_CTRL_RST 4'h0
`define UDC_FLAGS_RST 2'h0
`define UDC_MASK_RST 2'h0
`define UDC_ZERO_FLAG_RST 1'h1
`define UDC_FLAGS_INIT 2'h3

`endif

// ==== udc_pkg.sv ====
package udc_pkg;

    // Control inputs as written by software
    typedef struct packed {
        logic load;
        logic clear;
        logic down;
        logic up;
    } udc_ctrl_t;

    // Limit flags, also the layout of interrupt status and mask
    typedef struct packed {
        logic zero;
        logic upper;
    } udc_flags_t;

endpackage

// ==== udc_ctl_model.sv ====
module udc_ctl_model (
    input wire logic clk_i,
    input wire logic wb_ack_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle at time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    // One classic cycle; ctrl writes are how clear and load get released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        // Released address and data lines show the inverse so stale data is never reused
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        wb_adr_o <= ~a;
        wb_dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

// ==== test_up_down_counter.sv ====
`include "udc_regs.svh"

module test_up_down_counter
    import udc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] CT = `UDC_CTRL_OFS;
    localparam logic [7:0] PR = `UDC_PRESET_OFS;
    localparam logic [7:0] CN = `UDC_COUNT_OFS;
    localparam logic [7:0] FL = `UDC_FLAGS_OFS;
    localparam logic [7:0] ST = `UDC_IRQ_STAT_OFS;
    localparam logic [7:0] MK = `UDC_IRQ_MASK_OFS;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, upper_limit_flag_o;
    logic zero_flag_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed;
    logic [15:0] count_value_o, p;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    udc_ctl_model i_udc_ctl_model (.clk_i(clk_i), .wb_ack_i(wb_ack_o),
        .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
        .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

    udc_counter #(.WIDTH(16), .ADR_WIDTH(8)) i_udc_counter (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .count_value_o(count_value_o), .upper_limit_flag_o(upper_limit_flag_o),
        .zero_flag_o(zero_flag_o), .irq_o(irq_o));

    // 100 ns clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_udc_ctl_model.xfer(1'b1, a, d, 4'hf);
    endtask

    // Write with chosen byte lanes
    task automatic wrb(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        i_udc_ctl_model.xfer(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_udc_ctl_model.xfer(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic pulse(input logic [31:0] v);
        wr(CT, v);
        wr(CT, 32'h0);
    endtask

    // Port check once the counter update has landed; f is {zero, upper}
    task automatic port(input logic [15:0] c, input logic [1:0] f);
        repeat (2) @(posedge clk_i);
        cmp("count", c, count_value_o);
        cmp("flags", {14'h0, f}, {14'h0, zero_flag_o, upper_limit_flag_o});
    endtask

    task automatic irq(input logic e);
        cmp("irq", {15'h0, e}, {15'h0, irq_o});
    endtask

    task automatic conclude();
        if (exp_q.size() != 0) begin
            miscompares++;
        end
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Read data taken at the ack edge against the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0)
                cmp("read unexpected", 16'h0, 16'hffff);
            else begin
                cmp("read", exp_q.pop_front(), wb_dat_o[15:0]);
                cmp("read high", 16'h0, wb_dat_o[31:16]);
            end
        end
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        seed = 32'd56492;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(CT, 0);
        rd(PR, 0);
        rd(CN, 0);
        rd(FL, 3);
        rd(ST, 0);
        rd(MK, 0);
        rd(8'h1c, 0);
        irq(0);
        $display("test reset done");
        seed = xs(seed);
        p = 16'd2 + 16'(seed[1:0]);
        wr(MK, 3);
        wr(PR, {seed[31:16], p});
        port(0, 2'b10);
        for (int i = 1; i <= p; i++) begin
            pulse(1);
            port(16'(i), {1'b0, i == p});
        end
        pulse(1);
        port(p, 2'b01);
        irq(1);
        rd(ST, 1);
        irq(0);
        $display("test count up done");
        for (int i = p - 1; i >= 0; i--) begin
            pulse(2);
            port(16'(i), {i == 0, 1'b0});
        end
        pulse(2);
        port(0, 2'b10);
        wr(MK, 1);
        irq(0);
        rd(ST, 2);
        wr(MK, 3);
        $display("test count down done");
        wr(CT, 8);
        port(p, 2'b01);
        wr(CT, 9);
        wr(CT, 8);
        wr(CT, 10);
        port(p, 2'b01);
        wr(CT, 12);
        port(0, 2'b10);
        wr(CT, 13);
        wr(CT, 6);
        port(0, 2'b10);
        wr(CT, 0);
        irq(1);
        rd(ST, 3);
        $display("test load clear done");
        pulse(1);
        wr(CT, 3);
        wr(CT, 0);
        port(1, 2'b00);
        wr(CN, 32'h55);
        wr(8'h1c, seed);
        rd(CN, 1);
        rd(CT, 0);
        rd(PR, p);
        wrb(PR, 32'hffffffff, 4'h2);
        rd(PR, {8'hff, p[7:0]});
        port(1, 2'b00);
        $display("test both edges done");
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule
